// ==== core/nv_write_ctrl.sv ====
// self-timed erase-then-program controller for data and program memory
// assumes the core reaches it over Avalon-MM; resets arrive synchronous to clk_sys
//
// The placing of the registers and the Avalon-MM interface to the registers are this design's own decisions.
module nv_write_ctrl
    import nv_write_pkg::*;
#(
    parameter int ERASE_LEN   = ERASE_CYCLES,
    parameter int PROGRAM_LEN = PROGRAM_CYCLES,
    parameter int TIMER_W     = 16
) (
    input  wire logic                              clk_sys,
    input  wire logic                              rst,
    input  wire logic                              external_pin_reset,
    input  wire logic                              watchdog_timer_reset,
    input  wire logic [nv_write_pkg::BUS_ADDR_W-1:0] avs_address,
    input  wire logic                              avs_read,
    input  wire logic                              avs_write,
    input  wire logic [31:0]                       avs_writedata,
    input  wire logic [3:0]                        avs_byteenable,
    output logic [31:0]                            avs_readdata,
    output logic                                   avs_waitrequest,
    output logic                                   cpu_stall,
    output logic                                   mem_target,
    output logic [15:0]                            mem_addr,
    output logic [15:0]                            mem_wdata,
    output logic                                   mem_erase,
    output logic                                   mem_program,
    output logic                                   irq
);
    import nv_write_pkg::*;

    initial begin
        if (ERASE_LEN < 1 || PROGRAM_LEN < 1 || ERASE_LEN >= (1 << TIMER_W) || PROGRAM_LEN >= (1 << TIMER_W))
            $error("phase length does not fit the timer");
    end

    wr_state_t   state, next_state;
    unlock_t     unlock, next_unlock;
    logic        write_allow, next_write_allow;
    logic        write_start, next_write_start;
    logic        memory_select, next_memory_select;
    logic [7:0]  nv_addr_low, next_addr_low;
    logic [7:0]  nv_addr_high, next_addr_high;
    logic [7:0]  nv_data_low, next_data_low;
    logic [7:0]  nv_data_high, next_data_high;
    logic [IRQ_W-1:0] irq_enable, next_irq_enable;
    logic        next_target;
    logic [15:0] next_mem_addr, next_mem_wdata;
    logic        ack, next_ack;
    logic [31:0] next_readdata;
    logic        write_done_flag, write_abort_flag;
    logic        wr_strobe, hard_reset, busy, start_accept;
    logic        erase_expired, program_expired, finish;
    logic        clear_done, clear_abort;
    logic [IRQ_W-1:0] irq_status;

    // one wait state: the access completes on the cycle after it is seen
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    // a write lands only at the edge where waitrequest is low, never in the waiting cycle
    assign wr_strobe       = avs_write & ack & avs_byteenable[0];
    assign hard_reset      = external_pin_reset | watchdog_timer_reset;
    assign busy            = (state != ST_IDLE);
    assign finish          = (state == ST_PROGRAM) & program_expired & ~hard_reset;
    assign irq_status      = {write_abort_flag, write_done_flag};

    // start needs the allow bit from an earlier write and the unlock sequence
    assign start_accept = wr_strobe & (avs_address == OFS_CONTROL) & avs_writedata[BIT_START]
                        & write_allow & (unlock == UL_OPEN) & ~busy & ~hard_reset;

    assign clear_done  = wr_strobe & (avs_address == OFS_IRQ_CLEAR) & avs_writedata[IRQ_DONE];
    assign clear_abort = wr_strobe & (((avs_address == OFS_IRQ_CLEAR) & avs_writedata[IRQ_ABORT])
                       | ((avs_address == OFS_CONTROL) & ~avs_writedata[BIT_ABORT]));

    sticky_flag u_done_flag (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set     (finish),
        .clear   (clear_done),
        .flag    (write_done_flag)
    );

    sticky_flag u_abort_flag (
        .clk_sys (clk_sys),
        .rst     (rst),
        .set     (hard_reset & busy),
        .clear   (clear_abort),
        .flag    (write_abort_flag)
    );

    phase_timer #(.WIDTH(TIMER_W)) u_erase_timer (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .load       (start_accept),
        .load_value (TIMER_W'(ERASE_LEN)),
        .cancel     (hard_reset),
        .expired    (erase_expired)
    );

    phase_timer #(.WIDTH(TIMER_W)) u_program_timer (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .load       ((state == ST_ERASE) & erase_expired & ~hard_reset),
        .load_value (TIMER_W'(PROGRAM_LEN)),
        .cancel     (hard_reset),
        .expired    (program_expired)
    );

    // write sequencer: erase phase then program phase, both timed
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:    if (start_accept) next_state = ST_ERASE;
            ST_ERASE:   if (erase_expired) next_state = ST_PROGRAM;
            ST_PROGRAM: if (program_expired) next_state = ST_IDLE;
            default:    next_state = ST_IDLE;
        endcase
        if (hard_reset)
            next_state = ST_IDLE;
    end

    // software registers; pin and watchdog resets spare address, data and select
    always_comb begin
        next_unlock        = unlock;
        next_write_allow   = write_allow;
        next_write_start   = write_start;
        next_memory_select = memory_select;
        next_addr_low      = nv_addr_low;
        next_addr_high     = nv_addr_high;
        next_data_low      = nv_data_low;
        next_data_high     = nv_data_high;
        next_irq_enable    = irq_enable;
        if (wr_strobe) begin
            // any write other than the next unlock key relocks
            next_unlock = UL_LOCKED;
            unique case (avs_address)
                OFS_UNLOCK: begin
                    if (avs_writedata[7:0] == UNLOCK_FIRST)
                        next_unlock = UL_HALF;
                    else if (avs_writedata[7:0] == UNLOCK_SECOND && unlock == UL_HALF)
                        next_unlock = UL_OPEN;
                end
                OFS_CONTROL: begin
                    next_write_allow = avs_writedata[BIT_ALLOW]; // clearing it leaves a write running
                    if (!busy)
                        next_memory_select = avs_writedata[BIT_SELECT];
                end
                OFS_ADDR_LOW:   next_addr_low   = avs_writedata[7:0];
                OFS_ADDR_HIGH:  next_addr_high  = avs_writedata[7:0];
                OFS_DATA_LOW:   next_data_low   = avs_writedata[7:0];
                OFS_DATA_HIGH:  next_data_high  = avs_writedata[7:0];
                OFS_IRQ_ENABLE: next_irq_enable = avs_writedata[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (start_accept)
            next_write_start = 1'b1; // software can only set it
        if (finish)
            next_write_start = 1'b0;
        if (hard_reset) begin
            next_write_allow = 1'b0;
            next_write_start = 1'b0;
            next_unlock      = UL_LOCKED;
        end
    end

    // latch the target and operands at launch so later register writes cannot disturb the cycle
    always_comb begin
        next_target    = mem_target;
        next_mem_addr  = mem_addr;
        next_mem_wdata = mem_wdata;
        if (start_accept) begin
            next_target = memory_select;
            if (memory_select) begin
                next_mem_addr  = {nv_addr_high, nv_addr_low};
                next_mem_wdata = {nv_data_high, nv_data_low};
            end else begin
                next_mem_addr  = {8'h00, nv_addr_low};
                next_mem_wdata = {8'h00, nv_data_low};
            end
        end
    end

    // read data mux; unmapped addresses read zero
    always_comb begin
        next_ack      = (avs_read | avs_write) & ~ack;
        next_readdata = 32'h0000_0000;
        unique case (avs_address)
            OFS_CONTROL: begin
                next_readdata[BIT_SELECT] = memory_select;
                next_readdata[BIT_ABORT]  = write_abort_flag;
                next_readdata[BIT_ALLOW]  = write_allow;
                next_readdata[BIT_START]  = write_start;
            end
            OFS_ADDR_LOW:   next_readdata[7:0]       = nv_addr_low;
            OFS_ADDR_HIGH:  next_readdata[7:0]       = nv_addr_high;
            OFS_DATA_LOW:   next_readdata[7:0]       = nv_data_low;
            OFS_DATA_HIGH:  next_readdata[7:0]       = nv_data_high;
            OFS_IRQ_STATUS: next_readdata[IRQ_W-1:0] = irq_status;
            OFS_IRQ_ENABLE: next_readdata[IRQ_W-1:0] = irq_enable;
            default: ;
        endcase
    end

    // state registers; only power-on clears the data path registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state         <= ST_IDLE;
            unlock        <= UL_LOCKED;
            write_allow   <= 1'b0;
            write_start   <= 1'b0;
            memory_select <= 1'b0;
            nv_addr_low   <= 8'h00;
            nv_addr_high  <= 8'h00;
            nv_data_low   <= 8'h00;
            nv_data_high  <= 8'h00;
            irq_enable    <= '0;
            mem_target    <= 1'b0;
            mem_addr      <= 16'h0000;
            mem_wdata     <= 16'h0000;
            ack           <= 1'b0;
            avs_readdata  <= 32'h0000_0000;
        end else begin
            state         <= next_state;
            unlock        <= next_unlock;
            write_allow   <= next_write_allow;
            write_start   <= next_write_start;
            memory_select <= next_memory_select;
            nv_addr_low   <= next_addr_low;
            nv_addr_high  <= next_addr_high;
            nv_data_low   <= next_data_low;
            nv_data_high  <= next_data_high;
            irq_enable    <= next_irq_enable;
            mem_target    <= next_target;
            mem_addr      <= next_mem_addr;
            mem_wdata     <= next_mem_wdata;
            ack           <= next_ack;
            avs_readdata  <= next_readdata;
        end
    end

    // memory strobes and the core stall follow the registered state
    assign mem_erase   = (state == ST_ERASE);
    assign mem_program = (state == ST_PROGRAM);
    assign cpu_stall   = busy & mem_target;
    assign irq         = |(irq_status & irq_enable);

    no_start_unallowed_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept |-> $past(write_allow) || write_allow)
        else $error("start taken without write_allow");
    start_launch_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept |=> mem_erase && write_start)
        else $error("accepted start did not launch erase");
    start_self_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        finish |=> !write_start && !busy)
        else $error("start bit not cleared at completion");
    done_flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        finish |=> write_done_flag)
        else $error("completion did not set done flag");
    data_erase_addr_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept && !memory_select |=> mem_addr == {8'h00, $past(nv_addr_low)} && !mem_target)
        else $error("data write latched wrong address");
    data_no_stall_a: assert property (@(posedge clk_sys) disable iff (rst)
        busy && !mem_target |-> !cpu_stall)
        else $error("data write stalled the core");
    prog_stall_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept && memory_select |=> cpu_stall [*2])
        else $error("program write did not stall");
    prog_operands_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept && memory_select |=> mem_wdata == {$past(nv_data_high), $past(nv_data_low)})
        else $error("program write latched wrong data");
    prog_resume_a: assert property (@(posedge clk_sys) disable iff (rst)
        finish && mem_target |=> !cpu_stall && write_done_flag)
        else $error("core not released after program write");
    abort_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
        hard_reset && busy |=> write_abort_flag && !busy && !write_start)
        else $error("aborted write not flagged");
    regs_kept_a: assert property (@(posedge clk_sys) disable iff (rst)
        hard_reset && !wr_strobe |=> $stable(nv_addr_low) && $stable(nv_addr_high)
            && $stable(nv_data_low) && $stable(nv_data_high) && $stable(memory_select))
        else $error("pin or watchdog reset altered registers");
    select_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        busy && !hard_reset |=> $stable(memory_select))
        else $error("memory select changed during a write");
    unlock_need_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_accept |-> unlock == UL_OPEN && $past(unlock) == UL_OPEN)
        else $error("start taken without unlock sequence");
    allow_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        mem_erase && !write_allow && !erase_expired && !hard_reset |=> mem_erase)
        else $error("clearing write_allow aborted the write");
    phases_timed_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(mem_program) |-> $past(mem_erase) && $past(erase_expired))
        else $error("program phase began before erase expired");
    irq_level_a: assert property (@(posedge clk_sys) disable iff (rst)
        write_done_flag && irq_enable[IRQ_DONE] |-> irq)
        else $error("enabled done flag raised no interrupt");

    data_write_c: cover property (@(posedge clk_sys) disable iff (rst)
        start_accept && !memory_select ##[1:1000] finish);
    prog_write_c: cover property (@(posedge clk_sys) disable iff (rst)
        start_accept && memory_select ##[1:1000] finish);
    aborted_c: cover property (@(posedge clk_sys) disable iff (rst) hard_reset && busy);
    irq_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
endmodule

// ==== core/nv_write_pkg.sv ====
// constants, register map and states of the nonvolatile write controller
// assumes one 250 MHz clock and a 32-bit Avalon-MM slave port with byte addresses
package nv_write_pkg;
    localparam int        CLK_MHZ         = 250;
    localparam int        ERASE_TIME_NS   = 2000;
    localparam int        PROGRAM_TIME_NS = 2000;
    // least times round up to whole cycles
    localparam int        ERASE_CYCLES    = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int        PROGRAM_CYCLES  = (PROGRAM_TIME_NS * CLK_MHZ + 999) / 1000;

    localparam int        BUS_ADDR_W      = 6;
    localparam logic [5:0] OFS_CONTROL    = 6'h00;
    localparam logic [5:0] OFS_UNLOCK     = 6'h04;
    localparam logic [5:0] OFS_ADDR_LOW   = 6'h08;
    localparam logic [5:0] OFS_ADDR_HIGH  = 6'h0c;
    localparam logic [5:0] OFS_DATA_LOW   = 6'h10;
    localparam logic [5:0] OFS_DATA_HIGH  = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_CLEAR  = 6'h1c;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h20;

    // control register bit positions
    localparam int        BIT_START       = 1;
    localparam int        BIT_ALLOW       = 2;
    localparam int        BIT_ABORT       = 3;
    localparam int        BIT_SELECT      = 7;
    // interrupt status / clear / enable layout
    localparam int        IRQ_DONE        = 0;
    localparam int        IRQ_ABORT       = 1;
    localparam int        IRQ_W           = 2;

    localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND  = 8'haa;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ERASE   = 2'b01,
        ST_PROGRAM = 2'b11
    } wr_state_t;

    typedef enum logic [1:0] {
        UL_LOCKED = 2'b00,
        UL_HALF   = 2'b01,
        UL_OPEN   = 2'b11
    } unlock_t;
endpackage

// ==== core/phase_timer.sv ====
// down counter timing one erase or program phase
// assumes load is a one-cycle strobe; expired pulses on the last cycle
module phase_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_value,
    input  wire logic             cancel,
    output logic                  expired
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;

    initial begin
        if (WIDTH < 2)
            $error("phase_timer width too small");
    end

    assign expired = (count == WIDTH'(1));

    // load wins over the running count; cancel stops a phase cut short
    always_comb begin
        next_count = count;
        if (count != '0)
            next_count = count - WIDTH'(1);
        if (cancel)
            next_count = '0;
        if (load)
            next_count = load_value;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            count <= '0;
        else
            count <= next_count;
    end
endmodule

// ==== core/sticky_flag.sv ====
// one sticky status bit: hardware sets, software clears, set wins
// assumes set and clear are one-cycle synchronous strobes
module sticky_flag (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic set,
    input  wire logic clear,
    output logic      flag
);
    logic next_flag;

    // a set in the clearing cycle must not be lost
    always_comb begin
        next_flag = flag;
        if (clear)
            next_flag = 1'b0;
        if (set)
            next_flag = 1'b1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst)
            flag <= 1'b0;
        else
            flag <= next_flag;
    end
endmodule

// ==== verification/nv_memory_model.sv ====
// memory-side model: records each erase and program phase the controller drives
// assumes mem_erase and mem_program are levels and that address and data stand for the whole cycle
module nv_memory_model (
    input  wire logic        clk_sys,
    input  wire logic        mem_target,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        mem_erase,
    input  wire logic        mem_program,
    output logic      [15:0] erase_cycles,
    output logic      [15:0] program_cycles,
    output logic      [33:0] last_write,
    output logic      [7:0]  write_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev_erase = 1'b0;
    logic prev_prog  = 1'b0;
    initial begin
        erase_cycles = 16'h0;
        program_cycles = 16'h0;
        last_write = 34'h0;
        write_count = 8'h0;
    end
    // top bit of last_write: the program phase came straight after erase or program, never from idle
    always @(posedge clk_sys) begin
        prev_erase <= mem_erase;
        prev_prog <= mem_program;
        if (mem_erase) erase_cycles <= prev_erase ? erase_cycles + 16'h1 : 16'h1;
        if (mem_program) begin
            program_cycles <= prev_prog ? program_cycles + 16'h1 : 16'h1;
            last_write <= {prev_erase | prev_prog, mem_target, mem_addr, mem_wdata};
            if (!prev_prog) write_count <= write_count + 8'h1;
        end
    end
endmodule

// ==== verification/nv_write_ctrl_test.sv ====
// self-checking bench for the nonvolatile write controller
// assumes short phase lengths set here; memory side is the behavioural model
module nv_write_ctrl_test;
    import nv_write_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic sel; logic drop; logic [7:0] al, ah, dl, dh; logic [15:0] ea, ed;} row_t;
    logic clk_sys = 1'b0, rst = 1'b1, pin_rst = 1'b0, wdt_rst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic        avs_waitrequest, cpu_stall, mem_target, mem_erase, mem_program, irq;
    logic [15:0] mem_addr, mem_wdata, erase_cycles, program_cycles;
    logic [33:0] last_write;
    logic [7:0]  write_count;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    // data rows ignore the high bytes; drop rows clear write_allow mid-cycle
    row_t rows[4] = '{'{1'b0, 1'b0, 8'hff, 8'h5a, 8'hc3, 8'h11, 16'h00ff, 16'h00c3},
                      '{1'b1, 1'b0, 8'h34, 8'h12, 8'h78, 8'h3f, 16'h1234, 16'h3f78},
                      '{1'b0, 1'b1, 8'h00, 8'hff, 8'h00, 8'hff, 16'h0000, 16'h0000},
                      '{1'b1, 1'b1, 8'h01, 8'h80, 8'hff, 8'hff, 16'h8001, 16'hffff}};
    // erase long enough that a write_allow drop lands inside the erase phase
    localparam int ERASE_N = 6;
    localparam int PROG_N  = 3;
    nv_write_ctrl #(.ERASE_LEN(ERASE_N), .PROGRAM_LEN(PROG_N)) DUT (.clk_sys(clk_sys), .rst(rst),
        .external_pin_reset(pin_rst), .watchdog_timer_reset(wdt_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall),
        .mem_target(mem_target), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_erase(mem_erase),
        .mem_program(mem_program), .irq(irq));
    nv_memory_model mem_model (.clk_sys(clk_sys), .mem_target(mem_target), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_erase(mem_erase), .mem_program(mem_program), .erase_cycles(erase_cycles),
        .program_cycles(program_cycles), .last_write(last_write), .write_count(write_count));
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one Avalon transfer, entered just after a rising edge; the request stands until
    // waitrequest is sampled low at a rising edge, read data are taken at that edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic start_write(input logic sel);
        bus(1'b1, OFS_CONTROL, {sel, 7'h04});
        bus(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
        bus(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
        bus(1'b1, OFS_CONTROL, {sel, 7'h06});
    endtask
    task automatic set_regs(input logic [7:0] al, ah, dl, dh);
        bus(1'b1, OFS_ADDR_LOW, al);
        bus(1'b1, OFS_ADDR_HIGH, ah);
        bus(1'b1, OFS_DATA_LOW, dl);
        bus(1'b1, OFS_DATA_HIGH, dh);
    endtask
    // poll the start bit until the running write has finished
    task automatic wait_done();
        for (int n = 0; n < 20; n++) begin
            bus(1'b0, OFS_CONTROL, 8'h00);
            if (q[BIT_START] === 1'b0) break;
        end
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        bus(1'b0, OFS_CONTROL, 8'h00);
        check("control after reset", q, 32'h0);
        bus(1'b0, OFS_IRQ_STATUS, 8'h00);
        check("status after reset", q, 32'h0);
        foreach (rows[i]) begin
            set_regs(rows[i].al, rows[i].ah, rows[i].dl, rows[i].dh);
            bus(1'b1, OFS_IRQ_ENABLE, 8'h01);
            start_write(rows[i].sel);
            @(negedge clk_sys);
            check("cpu_stall running", cpu_stall, rows[i].sel);
            @(posedge clk_sys);
            if (rows[i].drop) bus(1'b1, OFS_CONTROL, {rows[i].sel, 7'h00});
            wait_done();
            check("start self clear", q[BIT_START], 32'h0);
            check("memory write", last_write, {1'b1, rows[i].sel, rows[i].ea, rows[i].ed});
            check("erase length", erase_cycles, ERASE_N);
            check("program length", program_cycles, PROG_N);
            check("write count", write_count, i + 1);
            @(negedge clk_sys);
            check("cpu_stall after", cpu_stall, 32'h0);
            check("irq on done", irq, 32'h1);
            @(posedge clk_sys);
            bus(1'b0, OFS_IRQ_STATUS, 8'h00);
            check("done flag", q, 32'h1);
            bus(1'b1, OFS_IRQ_ENABLE, 8'h00);
            check("irq masked", irq, 32'h0);
            bus(1'b1, OFS_IRQ_CLEAR, 8'h01);
            bus(1'b0, OFS_IRQ_STATUS, 8'h00);
            check("done cleared", q, 32'h0);
        end
        // refused starts: allow in the same write, no unlock, broken unlock
        bus(1'b1, OFS_CONTROL, 8'h00);
        bus(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
        bus(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
        bus(1'b1, OFS_CONTROL, 8'h06);
        bus(1'b0, OFS_CONTROL, 8'h00);
        check("start with allow", q[BIT_START], 32'h0);
        bus(1'b1, OFS_CONTROL, 8'h06);
        bus(1'b0, OFS_CONTROL, 8'h00);
        check("start no unlock", q[BIT_START], 32'h0);
        bus(1'b1, OFS_UNLOCK, UNLOCK_FIRST);
        bus(1'b1, OFS_ADDR_LOW, 8'h9c);
        bus(1'b1, OFS_UNLOCK, UNLOCK_SECOND);
        bus(1'b1, OFS_CONTROL, 8'h06);
        bus(1'b0, OFS_CONTROL, 8'h00);
        check("start broken unlock", q[BIT_START], 32'h0);
        check("refused count", write_count, 32'd4);
        // pin reset then watchdog reset cut a program write short
        for (int s = 0; s < 2; s++) begin
            set_regs(8'h9c, 8'h21, 8'h44, 8'h05);
            start_write(1'b1);
            repeat (2) @(posedge clk_sys);
            if (s == 0) pin_rst <= 1'b1;
            else wdt_rst <= 1'b1;
            @(posedge clk_sys);
            pin_rst <= 1'b0;
            wdt_rst <= 1'b0;
            @(posedge clk_sys);
            bus(1'b0, OFS_CONTROL, 8'h00);
            check("control after abort", q, 32'h88);
            bus(1'b0, OFS_ADDR_HIGH, 8'h00);
            check("addr kept", q, 32'h21);
            bus(1'b0, OFS_DATA_LOW, 8'h00);
            check("data kept", q, 32'h44);
            check("abort no write", write_count, 4 + s);
            check("stall released", cpu_stall, 32'h0);
            bus(1'b1, OFS_CONTROL, 8'h80);
            bus(1'b0, OFS_CONTROL, 8'h00);
            check("abort cleared", q, 32'h80);
            // software repeats the cut write; address and data survived the reset
            start_write(1'b1);
            wait_done();
            check("rewrite lands", last_write, {2'b11, 16'h219c, 16'h0544});
            bus(1'b1, OFS_IRQ_CLEAR, 8'h03);
        end
        bus(1'b0, 6'h24, 8'h00);
        check("unmapped read", q, 32'h0);
        bus(1'b0, OFS_IRQ_CLEAR, 8'h00);
        check("clear reads zero", q, 32'h0);
        stop_test();
    end
endmodule
